// [hw/dcec_irq_match.sv]
// module: matches an interrupt request number against a selected number under an enable
`timescale 1ns/1ps
module dcec_irq_match #(
    parameter int NUM_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq_valid,
    input wire logic [NUM_W-1:0] irq_num,
    input wire logic [NUM_W-1:0] sel_num,
    input wire logic enable,
    output logic hit
);

    typedef struct packed {
        logic hit;
    } dcec_match_state_t;

    dcec_match_state_t state_reg;
    dcec_match_state_t state_next;

    // a hit follows a matching request one cycle later and lasts as long as it; a cleared enable simply ignores the request
    always_comb
    begin
        state_next.hit = irq_valid && enable && (irq_num == sel_num);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign hit = state_reg.hit;

endmodule

// [hw/dcec_pkg.sv]
// package: register layout, reset values and carrier types for the channel event control block
package dcec_pkg;

    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] EVCTL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // event control field positions
    localparam int ABORT_IRQ_LSB = 16;
    localparam int START_IRQ_LSB = 8;
    localparam int FORCE_BIT = 7;
    localparam int SW_ABORT_BIT = 6;
    localparam int PAT_EN_BIT = 5;
    localparam int START_EN_BIT = 4;
    localparam int ABORT_EN_BIT = 3;

    // status field positions (status register is write-one-to-clear on the flag)
    localparam int ABORT_FLAG_BIT = 0;
    localparam int CHAN_EN_BIT = 1;
    localparam int BUSY_BIT = 2;

    // reset values
    localparam logic [7:0] IRQ_NUM_RESET = 8'hff;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // decoded trigger pulses; only start and abort go out toward the data mover
    typedef struct packed {
        logic start;
        logic abort;
        logic clear_enable;
    } dcec_trig_t;

    // stored configuration
    typedef struct packed {
        logic [7:0] abort_request_number;
        logic [7:0] start_request_number;
        logic pattern_abort_enable;
        logic start_trigger_enable;
        logic abort_trigger_enable;
    } dcec_cfg_t;

endpackage

// [hw/dcec_top.sv]
// module: event control register and trigger logic for one dma channel
`timescale 1ns/1ps
module dcec_top #(
    parameter int NUM_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic irq_valid,
    input wire logic [NUM_W-1:0] irq_num,
    input wire logic pattern_match,
    input wire logic transfer_done,
    input wire logic channel_enable_set,
    output logic xfer_start,
    output logic xfer_abort,
    output logic channel_enable,
    output logic channel_abort_flag,
    output logic xfer_busy
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        dcec_pkg::dcec_cfg_t cfg;
        dcec_pkg::dcec_trig_t trig;
        logic chan_en;
        logic abort_flag;
        logic busy;
        logic [31:0] rdata;
    } dcec_state_t;

    dcec_state_t state_reg;
    dcec_state_t state_next;
    logic start_hit;
    logic abort_hit;
    logic wr_evctl;
    logic wr_status;
    logic sw_start;
    logic sw_abort;
    logic pat_abort;
    logic any_abort;
    logic any_start;

    // ------------------------------------------------------------------
    // interrupt number matchers
    // ------------------------------------------------------------------
    // matcher output is registered, so interrupt-number triggers act two cycles after the request; pattern abort acts one cycle after the match
    dcec_irq_match #(.NUM_W(NUM_W)) u_start_match (
        .sys_clk(sys_clk),
        .rst(rst),
        .irq_valid(irq_valid),
        .irq_num(irq_num),
        .sel_num(state_reg.cfg.start_request_number),
        .enable(state_reg.cfg.start_trigger_enable),
        .hit(start_hit)
    );

    dcec_irq_match #(.NUM_W(NUM_W)) u_abort_match (
        .sys_clk(sys_clk),
        .rst(rst),
        .irq_valid(irq_valid),
        .irq_num(irq_num),
        .sel_num(state_reg.cfg.abort_request_number),
        .enable(state_reg.cfg.abort_trigger_enable),
        .hit(abort_hit)
    );

    // ------------------------------------------------------------------
    // decode of writes and trigger sources
    // ------------------------------------------------------------------
    assign wr_evctl = reg_wr && (reg_addr == dcec_pkg::EVCTL_OFFSET);
    assign wr_status = reg_wr && (reg_addr == dcec_pkg::STATUS_OFFSET);
    assign sw_start = wr_evctl && reg_wdata[dcec_pkg::FORCE_BIT];
    assign sw_abort = wr_evctl && reg_wdata[dcec_pkg::SW_ABORT_BIT];
    assign pat_abort = pattern_match && state_reg.cfg.pattern_abort_enable && state_reg.busy;
    assign any_abort = sw_abort || abort_hit || pat_abort;
    // abort wins over any start in the same cycle, so the channel stays idle
    assign any_start = (sw_start || start_hit) && !any_abort;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        if (wr_evctl)
        begin
            state_next.cfg.abort_request_number = reg_wdata[dcec_pkg::ABORT_IRQ_LSB +: 8];
            state_next.cfg.start_request_number = reg_wdata[dcec_pkg::START_IRQ_LSB +: 8];
            state_next.cfg.pattern_abort_enable = reg_wdata[dcec_pkg::PAT_EN_BIT];
            state_next.cfg.start_trigger_enable = reg_wdata[dcec_pkg::START_EN_BIT];
            state_next.cfg.abort_trigger_enable = reg_wdata[dcec_pkg::ABORT_EN_BIT];
        end
        state_next.trig.start = any_start;
        state_next.trig.abort = any_abort;
        state_next.trig.clear_enable = pat_abort;
        // busy runs from a start to done or abort
        if (any_abort || transfer_done)
            state_next.busy = 1'b0;
        else if (any_start)
            state_next.busy = 1'b1;
        // channel enable: set by the mover side, cleared by pattern abort
        if (pat_abort)
            state_next.chan_en = 1'b0;
        else if (channel_enable_set)
            state_next.chan_en = 1'b1;
        // interrupt-number abort sets the flag; set wins over a clear in the same cycle
        if (abort_hit)
            state_next.abort_flag = 1'b1;
        else if (wr_status && reg_wdata[dcec_pkg::ABORT_FLAG_BIT])
            state_next.abort_flag = 1'b0;
        // read data stands only in the cycle after the strobe
        state_next.rdata = dcec_pkg::RD_ZERO;
        if (reg_rd && reg_addr == dcec_pkg::EVCTL_OFFSET)
        begin
            // strobe bits and unimplemented ranges read as zero
            state_next.rdata[dcec_pkg::ABORT_IRQ_LSB +: 8] = state_reg.cfg.abort_request_number;
            state_next.rdata[dcec_pkg::START_IRQ_LSB +: 8] = state_reg.cfg.start_request_number;
            state_next.rdata[dcec_pkg::PAT_EN_BIT] = state_reg.cfg.pattern_abort_enable;
            state_next.rdata[dcec_pkg::START_EN_BIT] = state_reg.cfg.start_trigger_enable;
            state_next.rdata[dcec_pkg::ABORT_EN_BIT] = state_reg.cfg.abort_trigger_enable;
        end
        else if (reg_rd && reg_addr == dcec_pkg::STATUS_OFFSET)
        begin
            state_next.rdata[dcec_pkg::ABORT_FLAG_BIT] = state_reg.abort_flag;
            state_next.rdata[dcec_pkg::CHAN_EN_BIT] = state_reg.chan_en;
            state_next.rdata[dcec_pkg::BUSY_BIT] = state_reg.busy;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.cfg.abort_request_number <= dcec_pkg::IRQ_NUM_RESET;
            state_reg.cfg.start_request_number <= dcec_pkg::IRQ_NUM_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign reg_rdata = state_reg.rdata;
    assign xfer_start = state_reg.trig.start;
    assign xfer_abort = state_reg.trig.abort;
    assign channel_enable = state_reg.chan_en;
    assign channel_abort_flag = state_reg.abort_flag;
    assign xfer_busy = state_reg.busy;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // abort interrupt: flag and pulse together; the hardware set beats a software clear
    AST_ABORT_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        abort_hit |=> channel_abort_flag && xfer_abort)
        else $error("abort interrupt did not abort and flag");
    AST_FLAG_WINS: assert property (@(posedge sys_clk) disable iff (rst)
        (abort_hit && wr_status && reg_wdata[dcec_pkg::ABORT_FLAG_BIT])
        |=> channel_abort_flag)
        else $error("flag clear beat abort interrupt");
    // start selection both ways: no hit without a match, no enabled match without a hit
    AST_START_SEL: assert property (@(posedge sys_clk) disable iff (rst)
        start_hit |-> $past(irq_valid && irq_num == state_reg.cfg.start_request_number))
        else $error("start hit without matching number");
    AST_START_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
        (irq_valid && state_reg.cfg.start_trigger_enable && irq_num == state_reg.cfg.start_request_number)
        |=> start_hit)
        else $error("matching start number gave no hit");
    AST_FORCE: assert property (@(posedge sys_clk) disable iff (rst)
        (sw_start && !any_abort) |=> xfer_start)
        else $error("forced start missing");
    AST_SW_ABORT: assert property (@(posedge sys_clk) disable iff (rst)
        sw_abort |=> xfer_abort && !xfer_busy)
        else $error("software abort missing");
    AST_PAT: assert property (@(posedge sys_clk) disable iff (rst)
        pat_abort |=> !channel_enable && xfer_abort)
        else $error("pattern abort did not clear enable");
    // with pattern abort disabled a match must not abort on its own
    AST_PAT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        (pattern_match && !state_reg.cfg.pattern_abort_enable && !sw_abort && !abort_hit)
        |=> !xfer_abort)
        else $error("disabled pattern match aborted");
    AST_START_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
        (irq_valid && irq_num == state_reg.cfg.start_request_number && state_reg.cfg.start_trigger_enable
         && !sw_abort && !abort_hit && !pat_abort) |=> ##1 (xfer_start || xfer_abort))
        else $error("start interrupt lost");
    AST_START_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        (irq_valid && !state_reg.cfg.start_trigger_enable) |=> !start_hit)
        else $error("disabled start interrupt acted");
    AST_ABORT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        (irq_valid && !state_reg.cfg.abort_trigger_enable) |=> !abort_hit)
        else $error("disabled abort interrupt acted");
    // read data: zero in reserved and strobe bits, and zero outside the answer cycle
    AST_RD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == dcec_pkg::EVCTL_OFFSET) |=> (reg_rdata[31:24] == 8'h00 && reg_rdata[7:6] == 2'h0
         && reg_rdata[2:0] == 3'h0))
        else $error("unimplemented bits not zero");
    AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == dcec_pkg::RD_ZERO)
        else $error("read data outside answer cycle");
    // any abort source suppresses a start in the same cycle
    AST_PRIO: assert property (@(posedge sys_clk) disable iff (rst)
        (sw_start && sw_abort) |=> !xfer_start && !xfer_busy)
        else $error("abort did not win over forced start");
    AST_ABORT_SUPPRESS: assert property (@(posedge sys_clk) disable iff (rst)
        any_abort |=> !xfer_start)
        else $error("start issued beside an abort");

endmodule

// [verification/dcec_far_model.sv]
// far-side model: interrupt request sources and the channel data mover
`timescale 1ns/1ps
module dcec_far_model (
    input wire logic sys_clk,
    output logic irq_valid,
    output logic [7:0] irq_num,
    output logic pattern_match,
    output logic transfer_done,
    output logic channel_enable_set
);
    // quiet lines at time zero
    initial
    begin
        irq_valid = 1'h0;
        irq_num = 8'h00;
        pattern_match = 1'h0;
        transfer_done = 1'h0;
        channel_enable_set = 1'h0;
    end

    // one-cycle request; idle number flips so a stale number never matches by luck
    task automatic raise_irq(input logic [7:0] num);
        @(posedge sys_clk);
        irq_valid <= 1'h1;
        irq_num <= num;
        @(posedge sys_clk);
        irq_valid <= 1'h0;
        irq_num <= ~num;
    endtask

    // one-cycle mover pulse: 0 pattern match, 1 transfer done, 2 channel enable
    task automatic pulse(input int which);
        @(posedge sys_clk);
        pattern_match <= (which == 0);
        transfer_done <= (which == 1);
        channel_enable_set <= (which == 2);
        @(posedge sys_clk);
        {pattern_match, transfer_done, channel_enable_set} <= 3'h0;
    endtask
endmodule

// [verification/dcec_top_tb_top.sv]
// testbench: register accesses and trigger scenarios for the channel event control block
`timescale 1ns/1ps
module dcec_top_tb_top;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic irq_valid, pattern_match, transfer_done, channel_enable_set;
    logic [7:0] irq_num;
    logic xfer_start, xfer_abort, channel_enable, channel_abort_flag, xfer_busy;
    logic [31:0] rd_val;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    dcec_top dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_valid, .irq_num, .pattern_match, .transfer_done, .channel_enable_set,
        .xfer_start, .xfer_abort, .channel_enable, .channel_abort_flag, .xfer_busy);
    dcec_far_model far (.sys_clk, .irq_valid, .irq_num, .pattern_match, .transfer_done,
        .channel_enable_set);

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk32(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask

    // read data stands only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        rd_val = reg_rdata;
    endtask

    // configure, raise one interrupt, look at the pulses two cycles after it is raised
    task automatic trig(input logic [31:0] cfg, input logic [7:0] num, input logic es, input logic ea);
        wr(8'h00, cfg);
        far.raise_irq(num);
        @(posedge sys_clk);
        #1;
        chk1("irq start", es, xfer_start);
        chk1("irq abort", ea, xfer_abort);
    endtask

    // hang guard, well above the 73 or so cycles the sequence needs
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors++;
            final_report();
        end
    end

    // main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        rd(8'h00);
        chk32("evctl reset", 32'h00ffff00, rd_val);
        rd(8'h08);
        chk32("unmapped", 32'h0, rd_val);
        wr(8'h00, 32'hffffffff);
        #1;
        chk1("start", 1'h0, xfer_start);
        chk1("abort", 1'h1, xfer_abort);
        rd(8'h00);
        chk32("evctl ones", 32'h00ffff38, rd_val);
        wr(8'h00, 32'h00050490);
        #1;
        chk1("start", 1'h1, xfer_start);
        rd(8'h00);
        chk32("evctl", 32'h00050410, rd_val);
        far.pulse(1);
        #1;
        chk1("busy", 1'h0, xfer_busy);
        trig(32'h00050400, 8'h04, 1'h0, 1'h0);
        trig(32'h00050410, 8'h04, 1'h1, 1'h0);
        trig(32'h00050410, 8'h06, 1'h0, 1'h0);
        trig(32'h00000010, 8'h00, 1'h1, 1'h0);
        trig(32'h0000ff10, 8'hff, 1'h1, 1'h0);
        trig(32'h00050400, 8'h05, 1'h0, 1'h0);
        chk1("flag", 1'h0, channel_abort_flag);
        trig(32'h00050408, 8'h05, 1'h0, 1'h1);
        chk1("flag", 1'h1, channel_abort_flag);
        rd(8'h04);
        chk32("status", 32'h1, rd_val);
        wr(8'h04, 32'h1);
        #1;
        chk1("flag clr", 1'h0, channel_abort_flag);
        far.pulse(2);
        wr(8'h00, 32'h000000a0);
        far.pulse(0);
        #1;
        chk1("pat abort", 1'h1, xfer_abort);
        chk1("chan en", 1'h0, channel_enable);
        far.pulse(2);
        wr(8'h00, 32'h00000080);
        far.pulse(0);
        #1;
        chk1("pat off", 1'h0, xfer_abort);
        chk1("chan en", 1'h1, channel_enable);
        wr(8'h00, 32'h00000040);
        #1;
        chk1("sw abort", 1'h1, xfer_abort);
        @(posedge sys_clk);
        #1;
        chk1("busy", 1'h0, xfer_busy);
        final_report();
    end
endmodule
